// File: core/dsecc_pkg.sv
// Constants for the on-die SEC-DED status block of a DDR3 device.
// Assumes a single command clock domain; no other dependencies.
package dsecc_pkg;
   localparam int NIBBLE_W = 4;
   localparam int PARITY_W = 4;
   localparam int CODE_W = 8;
   localparam int CNT_W = 3;
   localparam logic [2:0] CNT_MAX = 3'h7;
   // Mode register 3 address field positions
   localparam int MR_A0 = 0;
   localparam int MR_A1 = 1;
   localparam int MR_A2 = 2;
   localparam int MR_A3 = 3;
   localparam int MR_A4 = 4;
   localparam int MR_DATA_LSB = 5;
   localparam logic [4:0] MR_WRITE_SEL = 5'h1F;
   localparam logic [2:0] MR3_BANK = 3'h3;
   // Register select codes {A4,A3,A1,A0}
   localparam logic [3:0] SEL_STATUS = 4'h4;
   localparam logic [3:0] SEL_LOC1 = 4'h5;
   localparam logic [3:0] SEL_LOC2 = 4'h6;
   localparam logic [3:0] SEL_LOC3 = 4'h7;
   localparam logic [3:0] SEL_LOC4 = 4'h8;
   localparam logic [3:0] SEL_CONFIG = 4'h9;
   // Configuration register fields
   localparam int CFG_ENABLE = 0;
   localparam int CFG_ALERT = 1;
   localparam int CFG_TYPE_LSB = 2;
   localparam int CFG_CLEAR = 4;
   localparam logic [3:0] CFG_RESET = 4'h1;
   // Alert type selection
   localparam logic [1:0] ALERT_SINGLE = 2'h0;
   localparam logic [1:0] ALERT_DOUBLE = 2'h1;
   localparam logic [1:0] ALERT_ANY = 2'h2;
   // Status register fields
   localparam int ST_EVENT = 0;
   localparam int ST_TYPE = 1;
   localparam int ST_SINGLE_LSB = 2;
   localparam int ST_DOUBLE_LSB = 5;
   localparam logic [7:0] REG_ZERO = 8'h00;
   typedef enum logic {
      DSECC_BANK_MODE,
      DSECC_BANK_REGS
   } dsecc_read_path_type;
endpackage

// File: core/dsecc_encode.sv
// Parity generator for one 4-bit half-byte (8-bit SEC-DED word).
// Purely combinational; used by the writer side of the top module.
`timescale 1ns/1ps
module dsecc_encode (
   input wire logic [3:0] data,
   output logic [3:0] parity
);
   // Hamming(7,4) checks plus overall parity for double detection
   always_comb begin
      parity[0] = data[0] ^ data[1] ^ data[3];
      parity[1] = data[0] ^ data[2] ^ data[3];
      parity[2] = data[1] ^ data[2] ^ data[3];
      parity[3] = ^data ^ parity[0] ^ parity[1] ^ parity[2];
   end
endmodule

// File: core/dsecc_decode.sv
// Checker and corrector for one 8-bit half-byte code word.
// Combinational; the top module registers its outputs.
`timescale 1ns/1ps
module dsecc_decode (
   input wire logic [3:0] data,
   input wire logic [3:0] parity,
   output logic [3:0] fixed,
   output logic single_err,
   output logic double_err
);
   logic [2:0] syn;
   logic overall;
   always_comb begin
      syn[0] = parity[0] ^ data[0] ^ data[1] ^ data[3];
      syn[1] = parity[1] ^ data[0] ^ data[2] ^ data[3];
      syn[2] = parity[2] ^ data[1] ^ data[2] ^ data[3];
      overall = ^data ^ ^parity;
      single_err = overall;
      double_err = !overall && (syn != 3'h0);
      fixed = data;
      // Positions: 3=d0 5=d1 6=d2 7=d3; parity-only flips leave data
      if (overall) begin
         unique case (syn)
            3'h3: fixed[0] = !data[0];
            3'h5: fixed[1] = !data[1];
            3'h6: fixed[2] = !data[2];
            3'h7: fixed[3] = !data[3];
            default: fixed = data;
         endcase
      end
   end
endmodule

// File: core/dsecc_core.sv
// On-die SEC-DED protection and status registers of a DDR3 device.
// Assumes the array, command decode and burst logic sit around it:
// array data and parity arrive with a read strobe, commands pre-decoded.
`timescale 1ns/1ps
module dsecc_core #(
   parameter int DATA_W = 16,
   parameter int BANK_W = 3,
   parameter int COL_W = 10,
   parameter int ROW_W = 15,
   parameter bit SERIAL_VARIANT = 1'b0
) (
   input wire logic clock,
   input wire logic arst_n,
   // Mode register set command with its address and bank lines
   input wire logic mrs_valid,
   input wire logic [2:0] mrs_bank,
   input wire logic [15:0] mrs_addr,
   // Serial-side register port, live only on the serial variant
   input wire logic serial_wr,
   input wire logic [3:0] serial_sel,
   input wire logic [4:0] serial_wdata,
   output logic [7:0] serial_rdata,
   // Write path towards the array
   input wire logic wr_valid,
   input wire logic [DATA_W-1:0] wr_data,
   output logic [DATA_W-1:0] wr_parity,
   output logic wr_parity_en,
   // Read path from the array, one beat per cycle within a burst
   input wire logic rd_valid,
   input wire logic rd_burst_start,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic [DATA_W-1:0] rd_parity,
   input wire logic [BANK_W-1:0] rd_bank,
   input wire logic [COL_W-1:0] rd_col,
   input wire logic [ROW_W-1:0] rd_row,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_valid,
   output logic mpr_active,
   output logic alert,
   output logic correction_enable
);
   localparam int NIB = DATA_W / dsecc_pkg::NIBBLE_W;

   logic rst_meta;
   logic rst_n;
   logic [3:0] cfg;
   logic alert_output_enable;
   logic [1:0] alert_type;
   logic event_flag;
   logic event_single;
   logic [2:0] single_count;
   logic [2:0] double_count;
   logic single_seen;
   logic double_seen;
   logic loc_valid;
   logic [BANK_W-1:0] loc_bank;
   logic [COL_W-1:0] loc_col;
   logic [ROW_W-1:0] loc_row;
   logic [3:0] mpr_sel;
   logic event_record_clear;
   logic [NIB-1:0] nib_single;
   logic [NIB-1:0] nib_double;
   logic [DATA_W-1:0] fixed_data;
   logic any_single;
   logic any_double;
   logic check_on;
   logic mr3_hit;
   logic cfg_write;
   logic [4:0] cfg_wdata;
   logic [3:0] reg_sel;
   logic [7:0] reg_value;
   logic [7:0] event_status_reg;
   logic [7:0] location_reg_one;
   logic [7:0] location_reg_two;
   logic [7:0] location_reg_three;
   logic [7:0] location_reg_four;
   logic [7:0] correction_config_reg;
   logic next_single_seen;
   logic next_double_seen;

   // Reset released through two flops
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   function automatic logic [2:0] sat_inc(input logic [2:0] value);
      sat_inc = (value == dsecc_pkg::CNT_MAX) ? value : value + 3'h1;
   endfunction

   assign correction_enable = cfg[dsecc_pkg::CFG_ENABLE];
   assign alert_output_enable = cfg[dsecc_pkg::CFG_ALERT];
   assign alert_type = cfg[dsecc_pkg::CFG_TYPE_LSB +: 2];
   assign check_on = correction_enable;

   // Mode register 3 decode; serial variant ignores it entirely
   assign mr3_hit = mrs_valid && !SERIAL_VARIANT
      && (mrs_bank == dsecc_pkg::MR3_BANK);
   assign cfg_write = SERIAL_VARIANT ? serial_wr
      : mr3_hit && (mrs_addr[4:0] == dsecc_pkg::MR_WRITE_SEL);
   assign cfg_wdata = SERIAL_VARIANT ? serial_wdata
      : mrs_addr[dsecc_pkg::MR_DATA_LSB +: 5];
   assign reg_sel = SERIAL_VARIANT ? serial_sel : mpr_sel;

   // Configuration register; clear bit is a pulse that self-returns
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= dsecc_pkg::CFG_RESET;
      end else if (cfg_write) begin
         cfg <= cfg_wdata[3:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         event_record_clear <= 1'b0;
      end else begin
         event_record_clear <= cfg_write
            && cfg_wdata[dsecc_pkg::CFG_CLEAR];
      end
   end

   // Multi-purpose register selection held from the last MR3 command
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mpr_active <= 1'b0;
         mpr_sel <= dsecc_pkg::SEL_STATUS;
      end else if (mr3_hit) begin
         mpr_active <= mrs_addr[dsecc_pkg::MR_A2];
         mpr_sel <= {mrs_addr[dsecc_pkg::MR_A4], mrs_addr[dsecc_pkg::MR_A3],
            mrs_addr[dsecc_pkg::MR_A1], mrs_addr[dsecc_pkg::MR_A0]};
      end
   end

   // Per half-byte encode and decode
   genvar g;
   generate
      for (g = 0; g < NIB; g++) begin : g_nib
         dsecc_encode u_enc (
            .data(wr_data[g*4 +: 4]),
            .parity(wr_parity[g*4 +: 4])
         );
         dsecc_decode u_dec (
            .data(rd_data[g*4 +: 4]),
            .parity(rd_parity[g*4 +: 4]),
            .fixed(fixed_data[g*4 +: 4]),
            .single_err(nib_single[g]),
            .double_err(nib_double[g])
         );
      end
   endgenerate

   // Parity kept as it was while correction is off
   assign wr_parity_en = wr_valid && check_on;

   assign any_single = rd_valid && check_on && !mpr_active
      && (|nib_single);
   assign any_double = rd_valid && check_on && !mpr_active
      && (|nib_double);

   // Seen flags restart at each burst so a counter moves once per burst
   always_comb begin
      next_single_seen = rd_burst_start ? 1'b0 : single_seen;
      next_double_seen = rd_burst_start ? 1'b0 : double_seen;
      if (any_single) begin
         next_single_seen = 1'b1;
      end
      if (any_double) begin
         next_double_seen = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         single_seen <= 1'b0;
         double_seen <= 1'b0;
      end else begin
         single_seen <= next_single_seen;
         double_seen <= next_double_seen;
      end
   end

   // Counters and flags; an event in the clear cycle survives the clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         single_count <= 3'h0;
         double_count <= 3'h0;
         event_flag <= 1'b0;
         event_single <= 1'b0;
      end else begin
         if (event_record_clear) begin
            single_count <= 3'h0;
            double_count <= 3'h0;
            event_flag <= 1'b0;
            event_single <= 1'b0;
         end
         if (any_single && (rd_burst_start || !single_seen)) begin
            single_count <= event_record_clear ? 3'h1
               : sat_inc(single_count);
         end
         if (any_double && (rd_burst_start || !double_seen)) begin
            double_count <= event_record_clear ? 3'h1
               : sat_inc(double_count);
         end
         if (any_single || any_double) begin
            event_flag <= 1'b1;
            event_single <= !any_double;
         end
      end
   end

   // First event address, held until cleared
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         loc_valid <= 1'b0;
         loc_bank <= '0;
         loc_col <= '0;
         loc_row <= '0;
      end else begin
         if (event_record_clear) begin
            loc_valid <= 1'b0;
            loc_bank <= '0;
            loc_col <= '0;
            loc_row <= '0;
         end
         if ((any_single || any_double)
               && (!loc_valid || event_record_clear)) begin
            loc_valid <= 1'b1;
            loc_bank <= rd_bank;
            loc_col <= rd_col;
            loc_row <= rd_row;
         end
      end
   end

   // Register images
   assign event_status_reg = {double_count, single_count,
      event_single, event_flag};
   assign location_reg_one = {loc_col[4:0], loc_bank[2:0]};
   assign location_reg_two = {3'h0, loc_col[9:5]};
   assign location_reg_three = loc_row[7:0];
   assign location_reg_four = {1'b0, loc_row[14:8]};
   // Clear bit never reads back as 1 since it self-returns
   assign correction_config_reg = {4'h0, cfg};

   always_comb begin
      unique case (reg_sel)
         dsecc_pkg::SEL_STATUS: reg_value = event_status_reg;
         dsecc_pkg::SEL_LOC1: reg_value = location_reg_one;
         dsecc_pkg::SEL_LOC2: reg_value = location_reg_two;
         dsecc_pkg::SEL_LOC3: reg_value = location_reg_three;
         dsecc_pkg::SEL_LOC4: reg_value = location_reg_four;
         dsecc_pkg::SEL_CONFIG: reg_value = correction_config_reg;
         default: reg_value = dsecc_pkg::REG_ZERO;
      endcase
   end

   // Read data out: array data, corrected only while correction is on, or register on DQ7..DQ0
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dq_out <= '0;
         dq_valid <= 1'b0;
         serial_rdata <= dsecc_pkg::REG_ZERO;
      end else begin
         dq_valid <= rd_valid;
         serial_rdata <= SERIAL_VARIANT ? reg_value
            : dsecc_pkg::REG_ZERO;
         if (rd_valid) begin
            if (mpr_active && !SERIAL_VARIANT) begin
               dq_out <= {{(DATA_W-8){1'b0}}, reg_value};
            end else if (check_on) begin
               dq_out <= fixed_data;
            end else begin
               dq_out <= rd_data;
            end
         end
      end
   end

   // Alert: set by the selected event kind, gated by both enables
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         alert <= 1'b0;
      end else if (event_record_clear || !correction_enable
            || !alert_output_enable) begin
         alert <= 1'b0;
      end else if ((any_single && alert_type != dsecc_pkg::ALERT_DOUBLE)
            || (any_double && alert_type != dsecc_pkg::ALERT_SINGLE)) begin
         alert <= 1'b1;
      end
   end
endmodule

// File: tb/dsecc_core_monitor.sv
// Port-level timing checks for the SEC-DED status block.
// Assumes the MR3 build; bound onto every dsecc_core instance.
`timescale 1ns/1ps
module dsecc_core_monitor #(
   parameter int DATA_W = 16,
   parameter bit SERIAL_VARIANT = 1'b0
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic mrs_valid,
   input wire logic [2:0] mrs_bank,
   input wire logic [15:0] mrs_addr,
   input wire logic [7:0] serial_rdata,
   input wire logic wr_valid,
   input wire logic wr_parity_en,
   input wire logic rd_valid,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic dq_valid,
   input wire logic mpr_active,
   input wire logic alert,
   input wire logic correction_enable
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic mr3;
   logic cfg_wr;
   assign mr3 = !SERIAL_VARIANT && mrs_valid && mrs_bank == 3'h3;
   assign cfg_wr = mr3 && mrs_addr[4:0] == dsecc_pkg::MR_WRITE_SEL;
   sequence s_clear;
      cfg_wr && mrs_addr[9] && !rd_valid;
   endsequence
   sequence s_quiet;
      !rd_valid [*3];
   endsequence
   // Reads during a clear may re-log, so only quiet clears count
   property p_clear_alert;
      s_clear ##1 s_quiet |=> !alert;
   endproperty
   property p_enable;
      cfg_wr |=> correction_enable == $past(mrs_addr[5]);
   endproperty
   property p_en_stable;
      !cfg_wr |=> $stable(correction_enable);
   endproperty
   property p_alert_gate;
      alert |-> correction_enable || $past(correction_enable);
   endproperty
   property p_parity_en;
      wr_parity_en == (wr_valid && correction_enable);
   endproperty
   property p_mpr;
      mr3 |=> mpr_active == $past(mrs_addr[2]);
   endproperty
   property p_mpr_upper;
      mpr_active && rd_valid |=> dq_out[DATA_W-1:8] == '0;
   endproperty
   property p_hold;
      !rd_valid |=> $stable(dq_out) && !dq_valid;
   endproperty
   property p_serial;
      serial_rdata == 8'h00;
   endproperty
   a_clear_alert: assert property (p_clear_alert)
      else $error("alert still high after clear");
   a_enable: assert property (p_enable)
      else $error("enable does not follow A5");
   a_en_stable: assert property (p_en_stable)
      else $error("enable changed without write");
   a_alert_gate: assert property (p_alert_gate)
      else $error("alert with correction off");
   a_parity_en: assert property (p_parity_en)
      else $error("parity write enable wrong");
   a_mpr: assert property (p_mpr)
      else $error("mpr mode does not follow A2");
   a_mpr_upper: assert property (p_mpr_upper)
      else $error("register read upper bits set");
   a_hold: assert property (p_hold)
      else $error("read data moved without read");
   a_serial: assert property (p_serial)
      else $error("serial port live on MR3 build");
endmodule
bind dsecc_core dsecc_core_monitor #(
   .DATA_W(DATA_W),
   .SERIAL_VARIANT(SERIAL_VARIANT)
) u_dsecc_core_monitor (.clock, .arst_n, .mrs_valid, .mrs_bank,
   .mrs_addr, .serial_rdata, .wr_valid, .wr_parity_en, .rd_valid,
   .dq_out, .dq_valid, .mpr_active, .alert, .correction_enable);

// File: tb/dsecc_ctrl_model.sv
// Controller and array stand-in: MR3 commands, one stored word.
// Assumes the core samples on rising edges; drives on falling ones.
`timescale 1ns/1ps
module dsecc_ctrl_model (
   input wire logic clock,
   output logic mrs_valid,
   output logic [2:0] mrs_bank,
   output logic [15:0] mrs_addr,
   output logic wr_valid,
   output logic [15:0] wr_data,
   input wire logic [15:0] wr_parity,
   input wire logic wr_parity_en,
   output logic rd_valid,
   output logic rd_burst_start,
   output logic [15:0] rd_data,
   output logic [15:0] rd_parity,
   output logic [2:0] rd_bank,
   output logic [9:0] rd_col,
   output logic [14:0] rd_row
);
   logic [15:0] mem_data;
   logic [15:0] mem_par;
   initial begin
      {mrs_valid, mrs_bank, mrs_addr, wr_valid, wr_data} = '0;
      {rd_valid, rd_burst_start, rd_data, rd_parity} = '0;
      {rd_bank, rd_col, rd_row, mem_data, mem_par} = '0;
   end
   // Old parity survives a write made with correction off
   always @(posedge clock) begin
      if (wr_valid) begin
         mem_data <= wr_data;
         if (wr_parity_en)
            mem_par <= wr_parity;
      end
   end
   // Any mode register; only bank 3 may reach the status block
   task automatic mrs_any(input logic [2:0] b, input logic [15:0] a);
      @(negedge clock);
      mrs_valid = 1'b1;
      mrs_bank = b;
      mrs_addr = a;
      @(negedge clock);
      mrs_valid = 1'b0;
      mrs_addr = ~a;
   endtask
   task automatic mrs(input logic [15:0] a);
      mrs_any(3'h3, a);
   endtask
   task automatic cfg(input logic [4:0] v);
      mrs({6'h00, v, 5'h1F});
      mrs(16'h0000);
   endtask
   task automatic sel(input logic [3:0] s);
      mrs({11'h000, s[3:2], 1'b1, s[1:0]});
   endtask
   task automatic write(input logic [15:0] d);
      @(negedge clock);
      wr_valid = 1'b1;
      wr_data = d;
      @(negedge clock);
      wr_valid = 1'b0;
      wr_data = ~d;
   endtask
   task automatic read(input logic [15:0] df, input logic [15:0] pf,
      input logic first, input logic [27:0] loc);
      @(negedge clock);
      rd_valid = 1'b1;
      rd_burst_start = first;
      rd_data = mem_data ^ df;
      rd_parity = mem_par ^ pf;
      {rd_bank, rd_col, rd_row} = loc;
      @(negedge clock);
      rd_valid = 1'b0;
      rd_burst_start = 1'b0;
      rd_data = ~rd_data;
      rd_parity = ~rd_parity;
   endtask
endmodule

// File: tb/dsecc_core_tb.sv
// Self-checking bench for dsecc_core, MR3 build.
// Assumes the controller model and the bound monitor.
`timescale 1ns/1ps
module dsecc_core_tb;
   typedef struct packed {
      logic [15:0] data;
      logic [15:0] dflip;
      logic [15:0] pflip;
      logic [15:0] exp;
   } dsecc_row_type;
   logic clock, arst_n, serial_wr, mrs_valid, wr_valid, wr_parity_en;
   logic rd_valid, rd_burst_start, dq_valid, mpr_active, alert;
   logic correction_enable;
   logic [2:0] mrs_bank, rd_bank;
   logic [3:0] serial_sel;
   logic [4:0] serial_wdata;
   logic [7:0] serial_rdata;
   logic [9:0] rd_col;
   logic [14:0] rd_row;
   logic [15:0] mrs_addr, wr_data, wr_parity, rd_data, rd_parity;
   logic [15:0] dq_out, q;
   int mismatches;
   int comparisons;
   dsecc_row_type rows [4];
   dsecc_core u_dsecc_core (.clock, .arst_n, .mrs_valid, .mrs_bank,
      .mrs_addr, .serial_wr, .serial_sel, .serial_wdata, .serial_rdata,
      .wr_valid, .wr_data, .wr_parity, .wr_parity_en, .rd_valid,
      .rd_burst_start, .rd_data, .rd_parity, .rd_bank, .rd_col, .rd_row,
      .dq_out, .dq_valid, .mpr_active, .alert, .correction_enable);
   dsecc_ctrl_model u_dsecc_ctrl_model (.clock, .mrs_valid, .mrs_bank,
      .mrs_addr, .wr_valid, .wr_data, .wr_parity, .wr_parity_en,
      .rd_valid, .rd_burst_start, .rd_data, .rd_parity, .rd_bank,
      .rd_col, .rd_row);
   always #10 clock = ~clock;
   function automatic logic [27:0] addr_of(input int i);
      return 28'h5B6_D39A ^ 28'(i);
   endfunction
   function automatic logic [7:0] st(input logic [2:0] d,
      input logic [2:0] s, input logic ty);
      return {d, s, ty, 1'b1};
   endfunction
   // Address word is {bank, column, row}
   function automatic logic [7:0] loc(input int n, input logic [27:0] a);
      case (n)
         1: return {a[19:15], a[27:25]};
         2: return {3'h0, a[24:20]};
         3: return a[7:0];
         default: return {1'b0, a[14:8]};
      endcase
   endfunction
   task automatic conclude;
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [15:0] df, input logic [15:0] pf,
      input logic first, input logic [27:0] a);
      u_dsecc_ctrl_model.read(df, pf, first, a);
      for (int k = 0; k < 4 && dq_valid !== 1'b1; k++)
         @(negedge clock);
      q = (dq_valid === 1'b1) ? dq_out : 'x;
   endtask
   task automatic reg_chk(input logic [3:0] s, input logic [7:0] exp);
      u_dsecc_ctrl_model.sel(s);
      rd(16'h0000, 16'h0000, 1'b1, 28'h000_0000);
      u_dsecc_ctrl_model.mrs(16'h0000);
      chk(q, {8'h00, exp});
   endtask
   initial begin
      #(5000 * 20);
      mismatches++;
      conclude();
   end
   initial begin
      clock = 1'b0;
      arst_n = 1'b0;
      {serial_wr, serial_sel, serial_wdata} = '0;
      mismatches = 0;
      comparisons = 0;
      rows[0] = {16'h1234, 16'h0000, 16'h0000, 16'h1234};
      rows[1] = {16'hA5C3, 16'h1111, 16'h0000, 16'hA5C3};
      rows[2] = {16'hBEEF, 16'h0000, 16'h8421, 16'hBEEF};
      rows[3] = {16'h0F0F, 16'h8000, 16'h0000, 16'h0F0F};
      repeat (6) @(negedge clock);
      arst_n = 1'b1;
      repeat (3) @(negedge clock);
      chk({correction_enable, alert, mpr_active}, 16'h0004);
      reg_chk(dsecc_pkg::SEL_CONFIG, 8'h01);
      reg_chk(dsecc_pkg::SEL_STATUS, 8'h00);
      foreach (rows[i]) begin
         u_dsecc_ctrl_model.write(rows[i].data);
         rd(rows[i].dflip, rows[i].pflip, 1'b1, addr_of(i));
         chk(q, rows[i].exp);
      end
      reg_chk(dsecc_pkg::SEL_STATUS, st(0, 3, 1));
      for (int n = 1; n < 5; n++)
         reg_chk(4'(4 + n), loc(n, addr_of(1)));
      u_dsecc_ctrl_model.read(16'h0003, 16'h0000, 1'b1, addr_of(9));
      u_dsecc_ctrl_model.read(16'h0031, 16'h0000, 1'b0, addr_of(9));
      reg_chk(dsecc_pkg::SEL_STATUS, 8'h31);
      reg_chk(dsecc_pkg::SEL_LOC1, loc(1, addr_of(1)));
      reg_chk(4'hA, 8'h00);
      @(negedge clock);
      {serial_wr, serial_sel, serial_wdata} = 10'h330;
      @(negedge clock);
      serial_wr = 1'b0;
      chk(correction_enable, 16'h0001);
      reg_chk(dsecc_pkg::SEL_STATUS, 8'h31);
      u_dsecc_ctrl_model.mrs_any(3'h2, 16'h001F);
      chk(correction_enable, 16'h0001);
      u_dsecc_ctrl_model.cfg(5'h11);
      reg_chk(dsecc_pkg::SEL_STATUS, 8'h00);
      reg_chk(dsecc_pkg::SEL_LOC1, 8'h00);
      reg_chk(dsecc_pkg::SEL_CONFIG, 8'h01);
      rd(16'h0003, 16'h0000, 1'b1, addr_of(12));
      reg_chk(dsecc_pkg::SEL_STATUS, st(1, 0, 0));
      reg_chk(dsecc_pkg::SEL_LOC4, loc(4, addr_of(12)));
      u_dsecc_ctrl_model.cfg(5'h11);
      repeat (9) rd(16'h0010, 16'h0000, 1'b1, addr_of(3));
      reg_chk(dsecc_pkg::SEL_STATUS, st(0, 7, 1));
      chk(alert, 16'h0000);
      u_dsecc_ctrl_model.cfg(5'h03);
      rd(16'h0010, 16'h0000, 1'b1, addr_of(3));
      reg_chk(dsecc_pkg::SEL_CONFIG, 8'h03);
      chk(alert, 16'h0001);
      u_dsecc_ctrl_model.cfg(5'h13);
      chk(alert, 16'h0000);
      u_dsecc_ctrl_model.cfg(5'h02);
      rd(16'h0010, 16'h0000, 1'b1, addr_of(3));
      chk(q, 16'h0F1F);
      chk({correction_enable, alert}, 16'h0000);
      u_dsecc_ctrl_model.cfg(5'h01);
      rd(16'h0200, 16'h0000, 1'b1, addr_of(3));
      chk(q, 16'h0F0F);
      conclude();
   end
endmodule
